// *** hdl/bass_top.sv ***
`timescale 1ns/10ps

module bass_top #(
	parameter int SWAP_CYCLES = bass_pkg::SWAP_CYCLES,
	parameter int DEBOUNCE_CYCLES = bass_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register access
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// gauge core measurement
	input wire bass_pkg::bass_meas_s meas_i,
	input wire logic meas_done_i,
	output logic meas_start_o,
	output logic restart_o,
	// supply lockout comparator, high while below lockout
	input wire logic uvlo_i,
	// alarm pin, open drain
	input wire logic alarm_pin_i,
	output logic alarm_pin_o,
	output logic alarm_pin_oe_o,
	// battery detect pin
	input wire logic detect_comparator_i,
	output logic detect_drive_high_o,
	output logic detect_drive_high_oe_o,
	// system reset line, open drain
	input wire logic reset_sense_i,
	output logic reset_hold_out_o,
	output logic reset_hold_out_oe_o
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	if (SWAP_CYCLES < 1 || SWAP_CYCLES >= (1 << bass_pkg::CNT_W)) begin : g_chk_swap
		$error("swap filter count does not fit the counter");
	end
	if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= (1 << bass_pkg::CNT_W)) begin : g_chk_deb
		$error("debounce count does not fit the counter");
	end

	localparam logic [27:0] SWAP_LAST = 28'(SWAP_CYCLES - 1);
	localparam logic [27:0] DEB_LAST = 28'(DEBOUNCE_CYCLES - 1);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic alarm_lvl;
	logic det_high;
	logic uvlo_low;
	logic rst_lvl;

	bass_sync #(.RST_VAL(1'b1)) u_sync_alarm (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i(alarm_pin_i),
		.q_o(alarm_lvl)
	);

	bass_sync #(.RST_VAL(1'b0)) u_sync_det (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i(detect_comparator_i),
		.q_o(det_high)
	);

	bass_sync #(.RST_VAL(1'b0)) u_sync_uvlo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i(uvlo_i),
		.q_o(uvlo_low)
	);

	bass_sync #(.RST_VAL(1'b1)) u_sync_rst (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i(reset_sense_i),
		.q_o(rst_lvl)
	);

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0] mode_r;
	logic drive_ctl_r;
	logic batfail_r;
	logic pordet_r;
	logic low_charge_flag_r;
	logic low_voltage_flag_r;
	logic [7:0] charge_lvl_r;
	logic [7:0] volt_lvl_r;
	logic [7:0] rdata_r;

	// address decode
	wire wr_mode = reg_wr_i && (reg_addr_i == bass_pkg::MODE_ADDR);
	wire wr_ctrl = reg_wr_i && (reg_addr_i == bass_pkg::CTRL_ADDR);
	wire wr_chg = reg_wr_i && (reg_addr_i == bass_pkg::CHARGE_LVL_ADDR);
	wire wr_volt = reg_wr_i && (reg_addr_i == bass_pkg::VOLT_LVL_ADDR);
	wire alarm_enable = mode_r[bass_pkg::MODE_ALM_EN_BIT];

	wire [7:0] ctrl_rd = {1'b0, low_voltage_flag_r, low_charge_flag_r, pordet_r, batfail_r, 2'b00, alarm_lvl};
	wire [7:0] rd_mux = (reg_addr_i == bass_pkg::MODE_ADDR) ? mode_r :
		(reg_addr_i == bass_pkg::CTRL_ADDR) ? ctrl_rd :
		(reg_addr_i == bass_pkg::CHARGE_LVL_ADDR) ? charge_lvl_r :
		(reg_addr_i == bass_pkg::VOLT_LVL_ADDR) ? volt_lvl_r : 8'h00;

	// ****************************************************************
	// alarm comparison
	// ****************************************************************
	logic meas_seen_r;
	logic chg_armed_r;
	logic volt_armed_r;
	logic alarm_oe_r;

	// thresholds scaled to the measurement lsb
	wire [16:0] chg_thr = 17'(charge_lvl_r) << bass_pkg::CHARGE_SHIFT;
	wire [10:0] volt_thr = 11'(volt_lvl_r) << bass_pkg::VOLT_SHIFT;
	wire chg_low = meas_seen_r && ({1'b0, meas_i.soc} < chg_thr);
	wire volt_low = meas_seen_r && (meas_i.volt < {1'b0, volt_thr});
	// independent trips, each gated by its own arming
	wire chg_trip = chg_low && chg_armed_r && alarm_enable && drive_ctl_r;
	wire volt_trip = volt_low && volt_armed_r && alarm_enable && drive_ctl_r;
	// re-arm only once the condition has gone
	wire chg_armed_nxt = chg_trip ? 1'b0 : (chg_low ? chg_armed_r : 1'b1);
	wire volt_armed_nxt = volt_trip ? 1'b0 : (volt_low ? volt_armed_r : 1'b1);

	// flags: set beats a same-cycle clear, write 1 is ignored
	wire chg_clr = wr_ctrl && !reg_wdata_i[bass_pkg::CTRL_LOWCHG_BIT];
	wire volt_clr = wr_ctrl && !reg_wdata_i[bass_pkg::CTRL_LOWVOLT_BIT];
	wire low_charge_nxt = chg_trip || (low_charge_flag_r && !chg_clr);
	wire low_voltage_nxt = volt_trip || (low_voltage_flag_r && !volt_clr);
	wire drive_nxt = wr_ctrl ? reg_wdata_i[bass_pkg::CTRL_DRIVE_BIT] : drive_ctl_r;
	// forced low by drive control 0
	// held low while either flag stands
	wire alarm_oe_nxt = !drive_nxt || low_charge_nxt || low_voltage_nxt;

	// ****************************************************************
	// power-up and swap sequencing
	// ****************************************************************
	bass_pkg::bass_state_e state_r;
	bass_pkg::bass_state_e state_nxt;
	logic [27:0] cnt_r;
	logic [27:0] cnt_nxt;
	logic meas_start_r;
	logic restart_r;
	logic det_drive_r;
	logic rst_hold_r;
	logic swap_evt;

	// a swap condition is either supply lockout or a high detect input
	wire swap_cond = uvlo_low || det_high;
	wire deb_done = (cnt_r == DEB_LAST);
	wire swap_done = (cnt_r == SWAP_LAST);

	// sequencer; the same counter serves debounce and swap filter
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		swap_evt = 1'b0;
		case (state_r)
			bass_pkg::ST_DEBOUNCE: begin
				if (swap_cond) begin
					cnt_nxt = 28'h0000000;
				end else if (deb_done) begin
					cnt_nxt = 28'h0000000;
					state_nxt = bass_pkg::ST_MEASURE;
				end else begin
					cnt_nxt = cnt_r + 28'h0000001;
				end
			end
			bass_pkg::ST_MEASURE: begin
				if (meas_done_i) begin
					state_nxt = bass_pkg::ST_RUN;
				end
			end
			bass_pkg::ST_RUN: begin
				// lockout held over the filter time
				// detect high held over the filter time
				if (!swap_cond) begin
					cnt_nxt = 28'h0000000;
				end else if (swap_done) begin
					cnt_nxt = 28'h0000000;
					swap_evt = 1'b1;
					state_nxt = bass_pkg::ST_SWAPPED;
				end else begin
					cnt_nxt = cnt_r + 28'h0000001;
				end
			end
			bass_pkg::ST_SWAPPED: begin
				// restart as at power-up once the condition has cleared
				if (!swap_cond) begin
					state_nxt = bass_pkg::ST_DEBOUNCE;
				end
			end
			default: begin
				state_nxt = bass_pkg::ST_DEBOUNCE;
				cnt_nxt = 28'h0000000;
			end
		endcase
	end

	wire enter_meas = (state_r == bass_pkg::ST_DEBOUNCE) && (state_nxt == bass_pkg::ST_MEASURE);
	wire leave_meas = (state_r == bass_pkg::ST_MEASURE) && (state_nxt == bass_pkg::ST_RUN);
	wire restart_evt = (state_r == bass_pkg::ST_SWAPPED) && (state_nxt == bass_pkg::ST_DEBOUNCE);
	// sample the reset line on entry; hold it only if it was low
	wire rst_hold_nxt = enter_meas ? !rst_lvl : (leave_meas ? 1'b0 : rst_hold_r);
	// drive detect high for the whole first measurement
	wire det_drive_nxt = enter_meas ? 1'b1 : (leave_meas ? 1'b0 : det_drive_r);

	// state, counter and pin controls
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= bass_pkg::ST_DEBOUNCE;
			cnt_r <= 28'h0000000;
			meas_start_r <= 1'b0;
			restart_r <= 1'b0;
			det_drive_r <= 1'b0;
			rst_hold_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			meas_start_r <= enter_meas;
			restart_r <= restart_evt;
			det_drive_r <= det_drive_nxt;
			rst_hold_r <= rst_hold_nxt;
		end
	end

	// first valid comparison only after a finished measurement
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meas_seen_r <= 1'b0;
		end else if (restart_evt) begin
			meas_seen_r <= 1'b0;
		end else if (meas_done_i) begin
			meas_seen_r <= 1'b1;
		end
	end

	// alarm arming and the open-drain enable
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chg_armed_r <= 1'b1;
			volt_armed_r <= 1'b1;
			alarm_oe_r <= 1'b0;
		end else begin
			chg_armed_r <= chg_armed_nxt;
			volt_armed_r <= volt_armed_nxt;
			alarm_oe_r <= alarm_oe_nxt;
		end
	end

	// mode and threshold registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// alarm enable reads 1 after reset
			mode_r <= bass_pkg::MODE_RST;
			charge_lvl_r <= bass_pkg::CHARGE_LVL_RST;
			volt_lvl_r <= bass_pkg::VOLT_LVL_RST;
		end else begin
			if (wr_mode) begin
				mode_r <= reg_wdata_i & bass_pkg::MODE_WMASK;
			end
			if (wr_chg) begin
				charge_lvl_r <= reg_wdata_i;
			end
			if (wr_volt) begin
				volt_lvl_r <= reg_wdata_i;
			end
		end
	end

	// control and status; hardware sets win over software clears
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			drive_ctl_r <= 1'b1;
			batfail_r <= 1'b0;
			pordet_r <= 1'b1;
			low_charge_flag_r <= 1'b0;
			low_voltage_flag_r <= 1'b0;
		end else begin
			// drive control written, not the pin level
			drive_ctl_r <= drive_nxt;
			batfail_r <= swap_evt || (batfail_r && !(wr_ctrl && !reg_wdata_i[bass_pkg::CTRL_BATFAIL_BIT]));
			pordet_r <= wr_ctrl ? reg_wdata_i[bass_pkg::CTRL_PORDET_BIT] : pordet_r;
			low_charge_flag_r <= low_charge_nxt;
			low_voltage_flag_r <= low_voltage_nxt;
		end
	end

	// registered read data
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_r <= rd_mux;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata_o = rdata_r;
	assign meas_start_o = meas_start_r;
	assign restart_o = restart_r;
	// open drain: the data level is always low, only the enable moves
	assign alarm_pin_o = 1'b0;
	assign alarm_pin_oe_o = alarm_oe_r;
	// detect pin driven to the supply level
	assign detect_drive_high_o = 1'b1;
	assign detect_drive_high_oe_o = det_drive_r;
	assign reset_hold_out_o = 1'b0;
	assign reset_hold_out_oe_o = rst_hold_r;

endmodule : bass_top

// *** hdl/bass_pkg.sv ***
package bass_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	// swap filter: the supply or detect level must persist longer than this
	localparam int SWAP_TIME_MS = 1000;
	localparam int SWAP_CYCLES = SWAP_TIME_MS * CYC_PER_MS;
	// startup and debounce delay before the first measurement (plain default)
	localparam int DEBOUNCE_TIME_MS = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * CYC_PER_MS;
	localparam int CNT_W = 28;

	// ****************************************************************
	// register access
	// ****************************************************************
	localparam int ADDR_W = 6;
	localparam logic [5:0] MODE_ADDR = 6'h00;
	localparam logic [5:0] CTRL_ADDR = 6'h01;
	localparam logic [5:0] CHARGE_LVL_ADDR = 6'h13;
	localparam logic [5:0] VOLT_LVL_ADDR = 6'h14;

	// mode register fields
	localparam int MODE_ALM_EN_BIT = 3;
	localparam logic [7:0] MODE_RST = 8'h09;
	localparam logic [7:0] MODE_WMASK = 8'h7f;

	// control and status register fields
	localparam int CTRL_DRIVE_BIT = 0;
	localparam int CTRL_BATFAIL_BIT = 3;
	localparam int CTRL_PORDET_BIT = 4;
	localparam int CTRL_LOWCHG_BIT = 5;
	localparam int CTRL_LOWVOLT_BIT = 6;

	// threshold resets: 2 half-percent steps, 170 steps of eight voltage lsb
	localparam logic [7:0] CHARGE_LVL_RST = 8'h02;
	localparam logic [7:0] VOLT_LVL_RST = 8'haa;
	// charge estimate lsb is 1/512 %, threshold lsb 0.5 %: shift by 8
	localparam int CHARGE_SHIFT = 8;
	// threshold step is eight voltage lsb: shift by 3
	localparam int VOLT_SHIFT = 3;

	localparam int SOC_W = 16;
	localparam int VOLT_W = 12;

	// one measurement result from the gauge core
	typedef struct packed {
		logic [SOC_W-1:0] soc;
		logic [VOLT_W-1:0] volt;
	} bass_meas_s;

	typedef enum {
		ST_DEBOUNCE,
		ST_MEASURE,
		ST_RUN,
		ST_SWAPPED
	} bass_state_e;

endpackage : bass_pkg

// *** hdl/bass_sync.sv ***
`timescale 1ns/10ps

// three-stage synchroniser; the output moves only when stages two and three agree
module bass_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// raw level and its filtered copy
	input wire logic d_i,
	output logic q_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic q_r;

	// first stage feeds only the second, so no logic sees a metastable value
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= (s2_r == s3_r) ? s3_r : q_r;
		end
	end

	assign q_o = q_r;

endmodule : bass_sync

// *** bench/bass_top_asserts.sv ***
`timescale 1ns/10ps

// ****************************************************************
// alarm and startup pin checks
// ****************************************************************
module bass_top_asserts #(
	parameter int SWAP_CYCLES = bass_pkg::SWAP_CYCLES,
	parameter int DEBOUNCE_CYCLES = bass_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register writes
	input wire logic reg_wr_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	// sequencer
	input wire logic meas_done_i,
	input wire logic meas_start_o,
	input wire logic restart_o,
	// pins
	input wire logic alarm_pin_o,
	input wire logic alarm_pin_oe_o,
	input wire logic detect_drive_high_o,
	input wire logic detect_drive_high_oe_o,
	input wire logic reset_hold_out_o,
	input wire logic reset_hold_out_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic seen_r;
	// control register writes
	wire ctrl_wr_w = reg_wr_i && reg_addr_i == bass_pkg::CTRL_ADDR;
	wire drv0_w = ctrl_wr_w && !reg_wdata_i[0];
	// a restart makes old data stale, so no trip may follow it until a new result
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			seen_r <= 1'b0;
		else if (restart_o)
			seen_r <= 1'b0;
		else if (meas_done_i)
			seen_r <= 1'b1;
	end
	a_drive_forces_low: assert property (drv0_w |=> alarm_pin_oe_o)
		else $error("alarm not forced low");
	a_alarm_sticky: assert property (alarm_pin_oe_o && !ctrl_wr_w |=> alarm_pin_oe_o)
		else $error("alarm released without a write");
	a_no_early_trip: assert property (!seen_r && !alarm_pin_oe_o && !drv0_w |=> !alarm_pin_oe_o)
		else $error("alarm before first result");
	a_idle_after_reset: assert property ($fell(rst_i) |-> !alarm_pin_oe_o && !reset_hold_out_oe_o)
		else $error("pin driven after reset");
	a_pin_levels: assert property (!alarm_pin_o && !reset_hold_out_o && detect_drive_high_o)
		else $error("pin driven to wrong level");
	a_start_drives_det: assert property (meas_start_o |-> detect_drive_high_oe_o)
		else $error("detect not driven at start");
	a_det_held: assert property (detect_drive_high_oe_o && !meas_done_i |=> detect_drive_high_oe_o)
		else $error("detect released early");
	a_hold_at_start: assert property ($rose(reset_hold_out_oe_o) |-> meas_start_o)
		else $error("reset hold outside start");
	a_hold_kept: assert property (reset_hold_out_oe_o && !meas_done_i |=> reset_hold_out_oe_o)
		else $error("reset hold dropped early");
	a_release_at_end: assert property (meas_done_i && detect_drive_high_oe_o
		|=> !detect_drive_high_oe_o && !reset_hold_out_oe_o)
		else $error("pins not released after measurement");
endmodule : bass_top_asserts

bind bass_top bass_top_asserts #(.SWAP_CYCLES(SWAP_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .meas_done_i(meas_done_i), .meas_start_o(meas_start_o),
	.restart_o(restart_o), .alarm_pin_o(alarm_pin_o), .alarm_pin_oe_o(alarm_pin_oe_o),
	.detect_drive_high_o(detect_drive_high_o), .detect_drive_high_oe_o(detect_drive_high_oe_o),
	.reset_hold_out_o(reset_hold_out_o), .reset_hold_out_oe_o(reset_hold_out_oe_o)
);

// *** bench/bass_partner.sv ***
`timescale 1ns/10ps

// ****************************************************************
// board and gauge core model
// ****************************************************************
module bass_partner #(
	parameter int MEAS_DLY = 8
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// gauge core handshake
	input wire logic meas_start_i,
	output logic meas_done_o,
	// pin enables from the device
	input wire logic alarm_oe_i,
	input wire logic det_oe_i,
	input wire logic rst_oe_i,
	// board conditions
	input wire logic batt_removed_i,
	input wire logic sys_hold_i,
	// resolved pin levels
	output logic alarm_pin_o,
	output logic det_high_o,
	output logic rst_line_o
);
	int cnt_r;
	// pull-ups on both open-drain lines; the system may also hold reset low
	assign alarm_pin_o = !alarm_oe_i;
	assign rst_line_o = !(rst_oe_i || sys_hold_i);
	assign det_high_o = det_oe_i || batt_removed_i;
	// one conversion lasts a fixed time; done is a one-cycle pulse
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 0;
			meas_done_o <= 1'b0;
		end else begin
			meas_done_o <= (cnt_r == 1);
			if (meas_start_i)
				cnt_r <= MEAS_DLY;
			else if (cnt_r != 0)
				cnt_r <= cnt_r - 1;
		end
	end
endmodule : bass_partner

// *** bench/test_battery_alarm_startup_sync.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_battery_alarm_startup_sync;
	typedef struct packed {logic wr; logic [5:0] a; logic [7:0] d; logic [7:0] e;} bass_row_s;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic uvlo_i = 1'b0, batt_rm = 1'b0, sys_hold = 1'b1;
	logic [5:0] reg_addr_i = 6'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	bass_pkg::bass_meas_s meas_i = '1;
	wire meas_done, meas_start, restart, alarm_pin, alarm_oe, det_cmp, det_oe, rst_line, rst_oe;
	int bad_count = 0, checked = 0, cyc = 0;
	bass_row_s rows [10] = '{'{1'b0, 6'h01, 8'h00, 8'h11}, '{1'b0, 6'h00, 8'h00, 8'h09},
		'{1'b0, 6'h13, 8'h00, 8'h02}, '{1'b0, 6'h14, 8'h00, 8'haa}, '{1'b1, 6'h14, 8'h55, 8'h55},
		'{1'b1, 6'h13, 8'hc8, 8'hc8}, '{1'b1, 6'h3f, 8'h77, 8'h00}, '{1'b1, 6'h00, 8'h89, 8'h09},
		'{1'b1, 6'h13, 8'h02, 8'h02}, '{1'b1, 6'h14, 8'haa, 8'haa}};

	bass_top #(.SWAP_CYCLES(50), .DEBOUNCE_CYCLES(20)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .meas_i(meas_i), .meas_done_i(meas_done), .meas_start_o(meas_start),
		.restart_o(restart), .uvlo_i(uvlo_i), .alarm_pin_i(alarm_pin), .alarm_pin_o(),
		.alarm_pin_oe_o(alarm_oe), .detect_comparator_i(det_cmp), .detect_drive_high_o(),
		.detect_drive_high_oe_o(det_oe), .reset_sense_i(rst_line), .reset_hold_out_o(),
		.reset_hold_out_oe_o(rst_oe));
	bass_partner pm_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .meas_start_i(meas_start),
		.meas_done_o(meas_done), .alarm_oe_i(alarm_oe), .det_oe_i(det_oe), .rst_oe_i(rst_oe),
		.batt_removed_i(batt_rm), .sys_hold_i(sys_hold), .alarm_pin_o(alarm_pin),
		.det_high_o(det_cmp), .rst_line_o(rst_line));

	// clock and a ceiling well above the expected run length
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ****************************************************************
	// bus and wait tasks
	// ****************************************************************
	task close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task cyc_n(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc_n
	task reg_wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [5:0] a);
		@(negedge ref_clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
	endtask : reg_rd
	task wait_start;
		for (int i = 0; i < 200 && meas_start !== 1'b1; i++) @(negedge ref_clk_i);
		`CHK(meas_start, 1'b1)
	endtask : wait_start
	task end_meas;
		for (int i = 0; i < 50 && meas_done !== 1'b1; i++) @(negedge ref_clk_i);
		@(negedge ref_clk_i);
		`CHK({det_oe, rst_oe}, 2'b00)
	endtask : end_meas
	// remove both conditions, then clear the flags and check that the alarm is released
	task clear_chk;
		meas_i = '1;
		cyc_n(2);
		reg_wr(6'h01, 8'h01);
		cyc_n(2);
		`CHK(alarm_oe, 1'b0)
	endtask : clear_chk
	task swap_src(input int s, input logic v);
		if (s == 0)
			uvlo_i = v;
		else
			batt_rm = v;
	endtask : swap_src

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		cyc_n(2);
		rst_i = 1'b0;
		@(negedge ref_clk_i);
		`CHK({alarm_oe, det_oe, rst_oe}, 3'b000)
		wait_start;
		`CHK({det_oe, rst_oe}, 2'b11)
		sys_hold = 1'b0;
		@(negedge ref_clk_i);
		`CHK(rst_line, 1'b0)
		end_meas;
		`CHK(alarm_oe, 1'b0)
		$display("test startup done");
		foreach (rows[i]) begin
			if (rows[i].wr)
				reg_wr(rows[i].a, rows[i].d);
			reg_rd(rows[i].a);
			`CHK(reg_rdata_o, rows[i].e)
		end
		$display("test registers done");
		meas_i.soc = 16'h0064;
		cyc_n(3);
		`CHK(alarm_oe, 1'b1)
		cyc_n(4);
		reg_rd(6'h01);
		`CHK(reg_rdata_o, 8'h30)
		meas_i.soc = 16'hffff;
		cyc_n(4);
		`CHK(alarm_oe, 1'b1)
		clear_chk;
		meas_i.soc = 16'h0064;
		cyc_n(3);
		reg_wr(6'h01, 8'h01);
		cyc_n(4);
		`CHK(alarm_oe, 1'b0)
		meas_i.volt = 12'h3e8;
		cyc_n(3);
		`CHK(alarm_oe, 1'b1)
		cyc_n(4);
		reg_rd(6'h01);
		`CHK(reg_rdata_o, 8'h40)
		clear_chk;
		meas_i.soc = 16'h0064;
		cyc_n(3);
		`CHK(alarm_oe, 1'b1)
		clear_chk;
		$display("test alarm done");
		reg_wr(6'h01, 8'h00);
		cyc_n(1);
		`CHK(alarm_oe, 1'b1)
		cyc_n(5);
		reg_rd(6'h01);
		`CHK(reg_rdata_o, 8'h00)
		reg_wr(6'h01, 8'h01);
		cyc_n(2);
		`CHK(alarm_oe, 1'b0)
		reg_wr(6'h00, 8'h01);
		meas_i.volt = 12'h3e8;
		cyc_n(4);
		`CHK(alarm_oe, 1'b0)
		clear_chk;
		reg_wr(6'h00, 8'h09);
		// a trip in the same cycle as a clear keeps its flag
		cyc_n(1);
		meas_i.soc = 16'h0064;
		reg_wr_i = 1'b1;
		reg_addr_i = 6'h01;
		reg_wdata_i = 8'h01;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		cyc_n(4);
		reg_rd(6'h01);
		`CHK(reg_rdata_o, 8'h20)
		clear_chk;
		$display("test drive done");
		for (int s = 0; s < 2; s++) begin
			swap_src(s, 1'b1);
			cyc_n(30);
			swap_src(s, 1'b0);
			cyc_n(10);
			reg_rd(6'h01);
			`CHK(reg_rdata_o, 8'h01)
			swap_src(s, 1'b1);
			cyc_n(70);
			reg_rd(6'h01);
			`CHK(reg_rdata_o, 8'h09)
			swap_src(s, 1'b0);
			for (int i = 0; i < 20 && restart !== 1'b1; i++) @(negedge ref_clk_i);
			`CHK(restart, 1'b1)
			wait_start;
			`CHK({det_oe, rst_oe}, 2'b10)
			end_meas;
			reg_wr(6'h01, 8'h01);
			$display("test swap %0d done", s);
		end
		close_out();
	end
endmodule : test_battery_alarm_startup_sync
